/* wwd_consts.svh */
// Offsets-free constants, widths, reset values and timing counts of the watchdog.
`ifndef WWD_CONSTS_SVH
`define WWD_CONSTS_SVH
`define WWD_CNT_W 24
`define WWD_FEED_W 8
`define WWD_FEED_FIRST 8'hAA
`define WWD_FEED_SECOND 8'h55
`define WWD_MIN_RELOAD 24'h0000FF
`define WWD_RST_RELOAD 24'h0000FF
`define WWD_RST_COUNT 24'h0000FF
`define WWD_RST_WARN 24'h000000
`define WWD_RST_WINDOW 24'hFFFFFF
`define WWD_PRESCALE_LAST 2'h3
`define WWD_SYNC_TICKS 2'h3
`endif

/* wwd_pkg.sv */
// Types shared by the windowed watchdog.
package wwd_pkg;
    typedef struct packed {
        logic reload_guard_mode;
        logic reset_on_timeout_enable;
        logic run_enable_bit;
    } wwd_mode_s;

    typedef struct packed {
        logic warning_flag;
        logic timeout_flag;
    } wwd_flags_s;

    typedef enum logic [0:0] {
        WWD_FEED_IDLE,
        WWD_FEED_ARMED
    } wwd_feed_e;
endpackage : wwd_pkg

/* wwd_top.sv */
// Windowed watchdog timer with feed sequence, window, warning and reload guard.
`timescale 1ns/10ps
`include "wwd_consts.svh"

module wwd_top #(
    parameter int CNT_W = `WWD_CNT_W
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cnt_clk_i,
    input wire logic mode_wr_i,
    input wire wwd_pkg::wwd_mode_s mode_wdata_i,
    input wire logic reload_wr_i,
    input wire logic [CNT_W-1:0] reload_wdata_i,
    input wire logic warn_wr_i,
    input wire logic [CNT_W-1:0] warn_wdata_i,
    input wire logic window_wr_i,
    input wire logic [CNT_W-1:0] window_wdata_i,
    input wire logic feed_wr_i,
    input wire logic [`WWD_FEED_W-1:0] feed_wdata_i,
    input wire logic timeout_clr_i,
    input wire logic warning_clr_i,
    output logic [CNT_W-1:0] count_readback_o,
    output wwd_pkg::wwd_mode_s mode_o,
    output wwd_pkg::wwd_flags_s flags_o,
    output logic running_o,
    output logic chip_reset_req_o,
    output logic clk_src_lock_o,
    output logic osc_keep_on_o
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [CNT_W-1:0] eff_reload(input logic [CNT_W-1:0] tc);
        eff_reload = (tc < CNT_W'(`WWD_MIN_RELOAD)) ? CNT_W'(`WWD_MIN_RELOAD) : tc;
    endfunction : eff_reload

    // ------------------------------------------------------------
    // Counting clock tick
    // ------------------------------------------------------------
    // The counting clock arrives from another source, so it is synchronised and
    // its rising edge becomes a one-cycle tick; clk_i must be well above its rate.
    logic cclk_s1_q, cclk_s2_q, cclk_s3_q;
    wire tick = cclk_s2_q & ~cclk_s3_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cclk_s1_q <= 1'b0;
            cclk_s2_q <= 1'b0;
            cclk_s3_q <= 1'b0;
        end else begin
            cclk_s1_q <= cnt_clk_i;
            cclk_s2_q <= cclk_s1_q;
            cclk_s3_q <= cclk_s2_q;
        end
    end

    // ------------------------------------------------------------
    // Register side
    // ------------------------------------------------------------
    wwd_pkg::wwd_mode_s mode_q;
    logic [CNT_W-1:0] reload_q, warn_q, window_q;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic guard_open;
    wire logic reload_take = reload_wr_i & (~mode_q.reload_guard_mode | guard_open);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mode_q <= '0;
            reload_q <= CNT_W'(`WWD_RST_RELOAD);
            warn_q <= CNT_W'(`WWD_RST_WARN);
            window_q <= CNT_W'(`WWD_RST_WINDOW);
        end else begin
            if (mode_wr_i) begin
                mode_q <= mode_q | mode_wdata_i;
            end
            if (reload_take) begin
                reload_q <= reload_wdata_i;
            end
            if (warn_wr_i) begin
                warn_q <= warn_wdata_i;
            end
            if (window_wr_i) begin
                window_q <= window_wdata_i;
            end
        end
    end

    // ------------------------------------------------------------
    // Crossing into the counting logic
    // ------------------------------------------------------------
    logic [1:0] sync_cnt_q;
    wwd_pkg::wwd_mode_s mode_sync_q;
    logic [CNT_W-1:0] reload_sync_q;
    wire logic sync_apply = tick && (sync_cnt_q == 2'h1);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync_cnt_q <= 2'h0;
            mode_sync_q <= '0;
            reload_sync_q <= CNT_W'(`WWD_RST_RELOAD);
        end else if (mode_wr_i || reload_take) begin
            sync_cnt_q <= `WWD_SYNC_TICKS;
        end else if (tick && sync_cnt_q != 2'h0) begin
            sync_cnt_q <= sync_cnt_q - 2'h1;
            if (sync_apply) begin
                mode_sync_q <= mode_q;
                reload_sync_q <= reload_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Feed sequence
    // ------------------------------------------------------------
    wwd_pkg::wwd_feed_e feed_q;
    wire logic feed_first = feed_wr_i && feed_wdata_i == `WWD_FEED_FIRST;
    wire logic feed_armed = feed_q == wwd_pkg::WWD_FEED_ARMED;
    wire logic feed_done = feed_wr_i && feed_armed && feed_wdata_i == `WWD_FEED_SECOND;
    wire logic feed_bad = feed_wr_i && feed_armed && feed_wdata_i != `WWD_FEED_SECOND;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            feed_q <= wwd_pkg::WWD_FEED_IDLE;
        end else begin
            unique case (feed_q)
                wwd_pkg::WWD_FEED_IDLE: begin
                    if (feed_first) begin
                        feed_q <= wwd_pkg::WWD_FEED_ARMED;
                    end
                end
                wwd_pkg::WWD_FEED_ARMED: begin
                    if (feed_wr_i) begin
                        feed_q <= wwd_pkg::WWD_FEED_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Counter, prescaler and events
    // ------------------------------------------------------------
    // The active mode only follows the synchronised copy at a complete feed.
    wwd_pkg::wwd_mode_s act_q;
    logic [1:0] pre_q;
    wwd_pkg::wwd_flags_s flags_q;
    logic rst_req_q;
    logic [CNT_W-1:0] cap_q, rb_q;
    logic cap_new_q;

    wire logic running = act_q.run_enable_bit;
    wire logic step = running && tick && pre_q == `WWD_PRESCALE_LAST;
    wire logic reach_zero = step && cnt_q == '0;
    wire logic early_feed = feed_done && running && cnt_q > window_q;
    wire logic wrong_feed = feed_bad && running;
    wire logic wd_event = reach_zero | early_feed | wrong_feed;
    wire logic warn_hit = step && cnt_q == warn_q;
    assign guard_open = cnt_q <= warn_q && cnt_q <= window_q;

    always_comb begin
        cnt_d = cnt_q;
        if (feed_done || reach_zero) begin
            cnt_d = eff_reload(reload_sync_q);
        end else if (step) begin
            cnt_d = cnt_q - CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            act_q <= '0;
            pre_q <= 2'h0;
            cnt_q <= CNT_W'(`WWD_RST_COUNT);
        end else begin
            cnt_q <= cnt_d;
            if (feed_done) begin
                act_q <= act_q | mode_sync_q;
                pre_q <= 2'h0;
            end else if (running && tick) begin
                pre_q <= pre_q + 2'h1;
            end
        end
    end

    // Set wins over clear for both flags; the clear inputs or the external reset clear them.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            flags_q <= '0;
            rst_req_q <= 1'b0;
        end else begin
            flags_q.timeout_flag <= wd_event | (flags_q.timeout_flag & ~timeout_clr_i);
            flags_q.warning_flag <= warn_hit | (flags_q.warning_flag & ~warning_clr_i);
            rst_req_q <= wd_event & act_q.reset_on_timeout_enable;
        end
    end

    // ------------------------------------------------------------
    // Count readback
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cap_q <= CNT_W'(`WWD_RST_COUNT);
            rb_q <= CNT_W'(`WWD_RST_COUNT);
            cap_new_q <= 1'b0;
        end else begin
            cap_new_q <= tick;
            if (tick) begin
                cap_q <= cnt_q;
            end
            if (cap_new_q) begin
                rb_q <= cap_q;
            end
        end
    end

    assign count_readback_o = rb_q;
    assign mode_o = act_q;
    assign flags_o = flags_q;
    assign running_o = running;
    assign chip_reset_req_o = rst_req_q;
    assign clk_src_lock_o = mode_q.run_enable_bit | running;
    assign osc_keep_on_o = running;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    run_sticky_a: assert property (running |=> running)
        else $error("Run bit dropped without reset.");
    lock_follow_a: assert property (running |-> clk_src_lock_o && osc_keep_on_o)
        else $error("Clock source not locked while running.");
    count_step_a: assert property (step && !feed_done && cnt_q != '0 |=> cnt_q == $past(cnt_q) - 1)
        else $error("Counter did not step by one.");
    no_step_a: assert property (!step && !feed_done && !reach_zero |=> $stable(cnt_q))
        else $error("Counter moved without a prescaled step.");
    min_reload_a: assert property (feed_done |=> cnt_q >= CNT_W'(`WWD_MIN_RELOAD))
        else $error("Reload below minimum.");
    wrong_feed_a: assert property (feed_bad && running |=> flags_q.timeout_flag)
        else $error("Bad feed not flagged.");
    zero_event_a: assert property (reach_zero |=> flags_q.timeout_flag && cnt_q != '0)
        else $error("Zero reach not flagged.");
    reset_req_a: assert property (chip_reset_req_o |-> $past(act_q.reset_on_timeout_enable))
        else $error("Chip reset without enable.");
    timeout_hold_a: assert property (flags_q.timeout_flag && !timeout_clr_i |=> flags_q.timeout_flag)
        else $error("Timeout flag lost.");
    warn_set_a: assert property (warn_hit |=> flags_q.warning_flag)
        else $error("Warning flag not set.");
    sync_delay_a: assert property (mode_wr_i ##1 (!mode_wr_i && !reload_wr_i) [*1] |-> sync_cnt_q == 2'h3)
        else $error("Sync delay not armed.");

    // Guarded reload writes are dropped, not queued, so software must write again later.
    guard_drop_a: assert property (mode_q.reload_guard_mode && reload_wr_i && !guard_open
        |=> $stable(reload_q))
        else $error("Guarded reload write taken.");
    mode_bits_a: assert property (mode_wr_i |=> (mode_q | $past(mode_q)) == mode_q)
        else $error("Set-only mode bit cleared.");
    early_evt_a: assert property (early_feed |=> flags_q.timeout_flag)
        else $error("Early feed not flagged.");
    start_run_a: assert property (feed_done && mode_sync_q.run_enable_bit |=> running)
        else $error("Feed did not start the watchdog.");
    feed_reload_a: assert property (feed_done
        |=> cnt_q == eff_reload($past(reload_sync_q)))
        else $error("Feed did not reload the counter.");
    cap_copy_a: assert property (cap_new_q |=> rb_q == $past(cap_q))
        else $error("Captured count not copied.");
    no_chip_reset_a: assert property (wd_event && !act_q.reset_on_timeout_enable
        |=> !chip_reset_req_o)
        else $error("Chip reset without enable.");
    warn_clear_a: assert property (warning_clr_i && flags_q.warning_flag && !warn_hit
        |=> !flags_q.warning_flag)
        else $error("Warning flag not cleared.");
    timeout_clear_a: assert property (timeout_clr_i && flags_q.timeout_flag && !wd_event
        |=> !flags_q.timeout_flag)
        else $error("Timeout flag not cleared.");

    feed_ok_c: cover property (feed_done && running && !early_feed);
    early_c: cover property (early_feed);
    timeout_c: cover property (reach_zero ##1 chip_reset_req_o);
    warn_c: cover property (warn_hit);
    guard_c: cover property (reload_wr_i && mode_q.reload_guard_mode && guard_open);

endmodule : wwd_top

/* wwd_top_tb.sv */
// Self-checking testbench for the windowed watchdog top level.
`timescale 1ns/10ps
module wwd_top_tb;
    logic clk_i, rst_n_i, cnt_clk_i, mode_wr, reload_wr, warn_wr, window_wr, feed_wr;
    logic t_clr, w_clr;
    wwd_pkg::wwd_mode_s mode_wd;
    logic [23:0] reload_wd, warn_wd, window_wd, rb;
    logic [7:0] feed_wd;
    wwd_pkg::wwd_mode_s mode_o;
    wwd_pkg::wwd_flags_s flags_o;
    logic running, rst_req, lock, osc;
    int err_total, compares, n;

    wwd_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .cnt_clk_i(cnt_clk_i),
        .mode_wr_i(mode_wr), .mode_wdata_i(mode_wd), .reload_wr_i(reload_wr),
        .reload_wdata_i(reload_wd), .warn_wr_i(warn_wr), .warn_wdata_i(warn_wd),
        .window_wr_i(window_wr), .window_wdata_i(window_wd), .feed_wr_i(feed_wr),
        .feed_wdata_i(feed_wd), .timeout_clr_i(t_clr), .warning_clr_i(w_clr),
        .count_readback_o(rb), .mode_o(mode_o), .flags_o(flags_o), .running_o(running),
        .chip_reset_req_o(rst_req), .clk_src_lock_o(lock), .osc_keep_on_o(osc));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // -----------------------------------------------------------------
    // Shared helpers
    // -----------------------------------------------------------------
    task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize

    task automatic cyc(input int k);
        repeat (k) @(negedge clk_i);
    endtask : cyc

    // Feed strobes rise on one falling edge and drop on the next, so the design sees one edge.
    task automatic feed(input logic [7:0] b);
        @(negedge clk_i);
        feed_wr = 1'b1;
        feed_wd = b;
        @(negedge clk_i);
        feed_wr = 1'b0;
    endtask : feed

    // Waits for the one-cycle reset request pulse and returns the cycles it took.
    task automatic wait_evt(input int lim, output int cnt);
        cnt = 0;
        while (rst_req !== 1'b1) begin
            @(negedge clk_i);
            cnt++;
            if (cnt > lim) begin
                chk("event wait", 24'h1, 24'h0);
                summarize();
            end
        end
        chk("timeout flag", flags_o.timeout_flag, 24'h1);
        @(negedge clk_i);
        chk("pulse width", rst_req, 24'h0);
        t_clr = 1'b1;
        @(negedge clk_i);
        t_clr = 1'b0;
        @(negedge clk_i);
        chk("flag cleared", flags_o.timeout_flag, 24'h0);
    endtask : wait_evt

    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task automatic t_reset();
        chk("readback", rb, 24'hFF);
        chk("mode", mode_o, 24'h0);
        chk("flags", flags_o, 24'h0);
        chk("run lock", {running, rst_req, lock, osc}, 24'h0);
    endtask : t_reset

    // A reload below the minimum is written first so the interval timed in t_timeout proves the clamp.
    task automatic t_start();
        @(negedge clk_i);
        reload_wr = 1'b1;
        reload_wd = 24'h10;
        mode_wr = 1'b1;
        mode_wd = 3'h3;
        @(negedge clk_i);
        reload_wr = 1'b0;
        mode_wd = 3'h0;
        cyc(2);
        chk("clock lock", lock, 24'h1);
        chk("not running", running, 24'h0);
        mode_wr = 1'b0;
        cyc(24);
        feed(8'hAA);
        feed(8'h55);
        cyc(3);
        chk("running", running, 24'h1);
        chk("active mode", mode_o, 24'h3);
        chk("osc on", osc, 24'h1);
    endtask : t_start

    task automatic t_rate();
        logic [23:0] v;
        n = 0;
        v = rb;
        while (rb === v && n < 40) begin
            cyc(1);
            n++;
        end
        if (n >= 40) begin
            chk("first step wait", 24'h1, 24'h0);
            summarize();
        end
        v = rb;
        n = 0;
        while (rb === v && n < 40) begin
            cyc(1);
            n++;
        end
        if (n >= 40) begin
            chk("next step wait", 24'h1, 24'h0);
            summarize();
        end
        chk("step cycles", n, 24'd16);
        chk("step size", rb, v - 24'h1);
    endtask : t_rate

    task automatic t_bad_feed();
        feed(8'hAA);
        feed(8'h12);
        wait_evt(6, n);
        chk("still running", running, 24'h1);
    endtask : t_bad_feed

    task automatic t_window();
        @(negedge clk_i);
        window_wr = 1'b1;
        window_wd = 24'h80;
        @(negedge clk_i);
        window_wr = 1'b0;
        feed(8'hAA);
        feed(8'h55);
        wait_evt(6, n);
        @(negedge clk_i);
        window_wr = 1'b1;
        window_wd = 24'hFFFFFF;
        @(negedge clk_i);
        window_wr = 1'b0;
    endtask : t_window

    // With 0xFF loaded, 256 steps of 16 system cycles pass before the zero event.
    task automatic t_timeout();
        @(negedge clk_i);
        warn_wr = 1'b1;
        warn_wd = 24'hF0;
        @(negedge clk_i);
        warn_wr = 1'b0;
        feed(8'hAA);
        feed(8'h55);
        chk("no warning yet", flags_o.warning_flag, 24'h0);
        wait_evt(4300, n);
        chk("interval ok", (n > 4070 && n < 4120), 24'h1);
        chk("warning flag", flags_o.warning_flag, 24'h1);
        w_clr = 1'b1;
        @(negedge clk_i);
        w_clr = 1'b0;
        @(negedge clk_i);
        chk("warning cleared", flags_o.warning_flag, 24'h0);
    endtask : t_timeout

    // A reload written while the count is above the warning value is lost; one written once it is at or below it lands.
    task automatic t_guard();
        @(negedge clk_i);
        mode_wr = 1'b1;
        mode_wd = 3'h4;
        @(negedge clk_i);
        mode_wr = 1'b0;
        reload_wr = 1'b1;
        reload_wd = 24'h200;
        @(negedge clk_i);
        reload_wr = 1'b0;
        cyc(16);
        feed(8'hAA);
        feed(8'h55);
        cyc(7);
        chk("guarded reload", rb, 24'hFF);
        chk("guard mode", mode_o, 24'h7);
        n = 0;
        while (rb > 24'hF0 && n < 400) begin
            cyc(1);
            n++;
        end
        if (n >= 400) begin
            chk("guard wait", 24'h1, 24'h0);
            summarize();
        end
        @(negedge clk_i);
        reload_wr = 1'b1;
        reload_wd = 24'h200;
        @(negedge clk_i);
        reload_wr = 1'b0;
        cyc(16);
        feed(8'hAA);
        feed(8'h55);
        cyc(7);
        chk("open reload", rb, 24'h200);
    endtask : t_guard

    // A second external reset clears the set-only bits; this run has no chip reset enabled.
    task automatic t_restart();
        rst_n_i = 1'b0;
        cyc(3);
        rst_n_i = 1'b1;
        cyc(1);
        t_reset();
        @(negedge clk_i);
        mode_wr = 1'b1;
        mode_wd = 3'h1;
        @(negedge clk_i);
        mode_wr = 1'b0;
        feed(8'hAA);
        feed(8'h55);
        chk("sync pending", running, 24'h0);
        cyc(16);
        feed(8'hAA);
        feed(8'h55);
        chk("restarted", mode_o, 24'h1);
        feed(8'hAA);
        feed(8'h12);
        chk("event flag", flags_o.timeout_flag, 24'h1);
        chk("no chip reset", rst_req, 24'h0);
        cyc(1);
        chk("still no reset", rst_req, 24'h0);
    endtask : t_restart

    initial begin
        err_total = 0;
        compares = 0;
        {rst_n_i, mode_wr, reload_wr, warn_wr, window_wr, feed_wr, t_clr, w_clr} = 8'h0;
        {cnt_clk_i, mode_wd, reload_wd, warn_wd, window_wd, feed_wd} = '0;
        fork
            forever begin
                cyc(2);
                cnt_clk_i = ~cnt_clk_i;
            end
        join_none
        cyc(16);
        rst_n_i = 1'b1;
        cyc(1);
        t_reset();
        t_start();
        t_rate();
        t_bad_feed();
        t_window();
        t_timeout();
        t_guard();
        t_restart();
        summarize();
    end
endmodule : wwd_top_tb
